/* File: shared/aux_tuning_pkg.sv */
`default_nettype none

package aux_tuning_pkg;

   // ----------------------------------------------------------------
   // Parameter addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] AUX_FUNC_ADDR = 16'h023c;
   localparam logic [15:0] SPEED_RESP_ADDR = 16'h023e;
   localparam logic [15:0] TUNING_MODE_ADDR = 16'h0240;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] AUX_FUNC_RESET = 16'h0000;
   localparam logic [15:0] SPEED_RESP_RESET = 16'h0050;
   localparam logic [15:0] TUNING_MODE_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Legal ranges
   // ----------------------------------------------------------------
   localparam logic signed [15:0] AUX_FUNC_MIN = -16'sh0008;
   localparam logic signed [15:0] AUX_FUNC_MAX = 16'sh0008;
   localparam logic [15:0] SPEED_RESP_MIN = 16'h0001;
   localparam logic [15:0] SPEED_RESP_MAX = 16'h03e8;
   localparam logic [15:0] TUNING_MODE_MAX = 16'h0002;

   // ----------------------------------------------------------------
   // Auxiliary function codes
   // ----------------------------------------------------------------
   localparam logic [15:0] AUX_NONE = 16'h0000;
   localparam logic [15:0] AUX_FORCE_SERVO_ON = 16'h0001;
   localparam logic [15:0] AUX_VOLATILE = 16'h0005;
   localparam logic [15:0] AUX_SIMULATION = 16'h0006;

   // ----------------------------------------------------------------
   // Tuning modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TUNE_MANUAL = 2'h0,
      TUNE_AUTO = 2'h1,
      TUNE_SEMI = 2'h2
   } tuning_mode_e;

   // ----------------------------------------------------------------
   // Stiffness bands, upper limits in Hz
   // ----------------------------------------------------------------
   localparam logic [15:0] BAND_LOW_MAX = 16'h0032;
   localparam logic [15:0] BAND_MED_MAX = 16'h00fa;
   localparam logic [15:0] BAND_HIGH_MAX = 16'h0226;
   localparam logic [1:0] BAND_NONE = 2'h0;
   localparam logic [1:0] BAND_LOW = 2'h1;
   localparam logic [1:0] BAND_MED = 2'h2;
   localparam logic [1:0] BAND_HIGH = 2'h3;

   // Position loop response is the speed level shifted right by this
   localparam int POS_RESP_SHIFT = 2;

   // ----------------------------------------------------------------
   // Gain switching threshold units
   // ----------------------------------------------------------------
   localparam logic [1:0] UNIT_NONE = 2'h0;
   localparam logic [1:0] UNIT_PULSE = 2'h1;
   localparam logic [1:0] UNIT_KPPS = 2'h2;
   localparam logic [1:0] UNIT_RPM = 2'h3;

   // Number of gain and filter parameters reloaded on return to manual
   localparam int GAIN_COUNT = 7;

   // Fault vector bit positions
   localparam int FLT_OVERCURRENT = 0;
   localparam int FLT_OVERLOAD = 1;
   localparam int FLT_OVERSPEED = 2;
   localparam int FLT_REV_LIMIT = 3;
   localparam int FLT_FWD_LIMIT = 4;
   localparam int FLT_ESTOP = 5;
   localparam int FLT_WIDTH = 6;
   localparam logic [FLT_WIDTH-1:0] MOTOR_FAULT_MASK = 6'h07;

endpackage

`default_nettype wire

/* File: core/aux_function_tuning_params.sv */
// Notes on behaviour
// R1: Gain switch threshold unit follows condition: pulse error, Kpps or r/min.
// R2: Selector zero disables forced servo-on, volatile storage and simulation.
// R3: Selector one forces servo-on regardless of the external input.
// R4: Selector five blocks nonvolatile writes; later values lost at power-down.
// R5: Host sets selector five before communication control to spare storage.
// R6: Selector six enters simulation: commands accepted, motor never driven.
// R7: Simulation disables the servo-on output whatever the external input.
// R8: Simulation reports the processor error code as zero.
// R9: Simulation suppresses overcurrent, overload and overspeed reports.
// R10: Simulation fault display shows only limits and emergency stop.
// R11: Operator keeps selector at zero in normal operation.
// R12: Selector clears to zero at every power-up.
// R13: Speed response classed low 1-50, medium 51-250, high 251-550 Hz.
// R14: Position loop response derives from the speed response level.
// R15: Speed response level acts only in auto or semi-auto tuning.
// R16: Tuning mode accepts 0 manual, 1 auto, 2 semi-auto.
// R17: Manual mode leaves the seven gain parameters to the user.
// R18: Leaving auto or semi-auto for manual loads the measured gains.
// R19: Out-of-range writes are rejected and the old value kept.
`timescale 1ns/10ps
`default_nettype none

module aux_function_tuning_params
   import aux_tuning_pkg::*;
(
   input wire logic sys_clk, // 50 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic [15:0] param_addr, // Parameter address
   input wire logic [15:0] param_wr_data, // Write value
   input wire logic param_wr, // Write strobe
   input wire logic param_rd, // Read strobe
   output logic [15:0] param_rd_data, // Read value
   output logic param_ack, // Access accepted
   output logic param_err, // Access refused
   input wire logic servo_on_in, // External servo-on pin
   input wire logic [FLT_WIDTH-1:0] fault_in, // Raw fault pins
   input wire logic [7:0] dsp_error_code, // Processor error code
   input wire logic [3:0] gain_switch_condition, // Switching condition
   input wire logic [31:0] gain_switch_threshold, // Threshold value
   output logic servo_on_output, // Servo-on to power stage
   output logic nv_store_enable, // Allow nonvolatile writes
   output logic simulation_mode, // Motor drive inhibited
   output logic [7:0] dsp_error_out, // Reported error code
   output logic [FLT_WIDTH-1:0] fault_display, // Shown faults
   output logic [1:0] threshold_unit, // Meaning of threshold
   output logic [31:0] threshold_value, // Threshold value held
   output logic [1:0] stiffness_band, // Active stiffness band
   output logic [15:0] speed_response_eff, // Active speed response
   output logic [15:0] pos_response, // Position loop response
   output logic gain_auto_update, // Tuner may rewrite gains
   output logic gain_load_measured // Load measured gains, pulse
);

   // ----------------------------------------------------------------
   // Registers and synchronisers
   // ----------------------------------------------------------------
   logic [15:0] aux_function_code_reg;
   logic [15:0] speed_response_level_reg;
   tuning_mode_e tuning_mode_code_reg;
   logic servo_meta_reg;
   logic servo_sync_reg;
   logic [FLT_WIDTH-1:0] fault_meta_reg;
   logic [FLT_WIDTH-1:0] fault_sync_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         servo_meta_reg <= 1'b0;
         servo_sync_reg <= 1'b0;
         fault_meta_reg <= '0;
         fault_sync_reg <= '0;
      end else begin
         servo_meta_reg <= servo_on_in;
         servo_sync_reg <= servo_meta_reg;
         fault_meta_reg <= fault_in;
         fault_sync_reg <= fault_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Access decode and range checks
   // ----------------------------------------------------------------
   wire sel_aux = (param_addr == AUX_FUNC_ADDR);
   wire sel_speed = (param_addr == SPEED_RESP_ADDR);
   wire sel_mode = (param_addr == TUNING_MODE_ADDR);
   wire sel_any = sel_aux | sel_speed | sel_mode;

   wire aux_ok = ($signed(param_wr_data) >= AUX_FUNC_MIN) &&
                 ($signed(param_wr_data) <= AUX_FUNC_MAX); // R19
   wire speed_ok = (param_wr_data >= SPEED_RESP_MIN) &&
                   (param_wr_data <= SPEED_RESP_MAX); // R19
   wire mode_ok = (param_wr_data <= TUNING_MODE_MAX); // R16 R19

   wire value_ok = (sel_aux & aux_ok) | (sel_speed & speed_ok) |
                   (sel_mode & mode_ok);
   wire wr_take = param_wr & sel_any & value_ok;
   wire rd_take = param_rd & ~param_wr & sel_any;

   wire [15:0] rd_mux = sel_aux ? aux_function_code_reg :
                        sel_speed ? speed_response_level_reg :
                        {14'h0000, tuning_mode_code_reg};

   // ----------------------------------------------------------------
   // Parameter storage
   // ----------------------------------------------------------------
   tuning_mode_e mode_next;
   assign mode_next = tuning_mode_e'(param_wr_data[1:0]);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aux_function_code_reg <= AUX_FUNC_RESET; // R12
         speed_response_level_reg <= SPEED_RESP_RESET;
         tuning_mode_code_reg <= TUNE_MANUAL;
      end else if (wr_take) begin
         if (sel_aux) begin
            aux_function_code_reg <= param_wr_data;
         end
         if (sel_speed) begin
            speed_response_level_reg <= param_wr_data;
         end
         if (sel_mode) begin
            tuning_mode_code_reg <= mode_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // Access answer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         param_rd_data <= 16'h0000;
         param_ack <= 1'b0;
         param_err <= 1'b0;
      end else begin
         param_ack <= wr_take | rd_take;
         param_err <= (param_wr | param_rd) & ~(wr_take | rd_take); // R19
         if (rd_take) begin
            param_rd_data <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Auxiliary functions
   // ----------------------------------------------------------------
   wire force_on = (aux_function_code_reg == AUX_FORCE_SERVO_ON); // R2 R3
   wire volatile_store = (aux_function_code_reg == AUX_VOLATILE); // R2 R4
   wire sim = (aux_function_code_reg == AUX_SIMULATION); // R2 R6

   wire servo_next = ~sim & (force_on | servo_sync_reg); // R3 R7
   wire [FLT_WIDTH-1:0] fault_next =
      sim ? (fault_sync_reg & ~MOTOR_FAULT_MASK) : fault_sync_reg; // R9 R10
   wire [7:0] dsp_next = sim ? 8'h00 : dsp_error_code; // R8

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         servo_on_output <= 1'b0;
         nv_store_enable <= 1'b1;
         simulation_mode <= 1'b0;
         dsp_error_out <= 8'h00;
         fault_display <= '0;
      end else begin
         servo_on_output <= servo_next; // R6 R7
         nv_store_enable <= ~volatile_store; // R4
         simulation_mode <= sim; // R6
         dsp_error_out <= dsp_next; // R8
         fault_display <= fault_next; // R9 R10
      end
   end

   // ----------------------------------------------------------------
   // Gain switching threshold unit
   // ----------------------------------------------------------------
   function automatic logic [1:0] unit_of(input logic [3:0] cond);
      case (cond)
         4'h2, 4'h6: unit_of = UNIT_PULSE;
         4'h3, 4'h7: unit_of = UNIT_KPPS;
         4'h4, 4'h8: unit_of = UNIT_RPM;
         default: unit_of = UNIT_NONE;
      endcase
   endfunction

   wire [1:0] unit_next = unit_of(gain_switch_condition); // R1

   // ----------------------------------------------------------------
   // Tuning response and gain handling
   // ----------------------------------------------------------------
   function automatic logic [1:0] band_of(input logic [15:0] lvl);
      if (lvl == 16'h0000) begin
         band_of = BAND_NONE;
      end else if (lvl <= BAND_LOW_MAX) begin
         band_of = BAND_LOW;
      end else if (lvl <= BAND_MED_MAX) begin
         band_of = BAND_MED;
      end else if (lvl <= BAND_HIGH_MAX) begin
         band_of = BAND_HIGH;
      end else begin
         band_of = BAND_NONE;
      end
   endfunction

   wire tuning_auto = (tuning_mode_code_reg == TUNE_AUTO) ||
                      (tuning_mode_code_reg == TUNE_SEMI); // R15
   wire [15:0] eff_next = tuning_auto ? speed_response_level_reg
                                      : 16'h0000; // R15
   wire [1:0] band_next = band_of(eff_next); // R13
   wire [15:0] pos_next = eff_next >> POS_RESP_SHIFT; // R14
   wire to_manual = wr_take & sel_mode & tuning_auto &
                    (mode_next == TUNE_MANUAL); // R18

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         threshold_unit <= UNIT_NONE;
         threshold_value <= 32'h0000_0000;
         stiffness_band <= BAND_NONE;
         speed_response_eff <= 16'h0000;
         pos_response <= 16'h0000;
         gain_auto_update <= 1'b0;
         gain_load_measured <= 1'b0;
      end else begin
         threshold_unit <= unit_next; // R1
         threshold_value <= gain_switch_threshold;
         stiffness_band <= band_next; // R13
         speed_response_eff <= eff_next; // R15
         pos_response <= pos_next; // R14
         gain_auto_update <= tuning_auto; // R17
         gain_load_measured <= to_manual; // R18
      end
   end

endmodule

`default_nettype wire

/* File: bench/aux_tuning_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module aux_tuning_checker
   import aux_tuning_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic [15:0] param_addr, // Address
   input wire logic [15:0] param_wr_data, // Write value
   input wire logic param_wr, // Write strobe
   input wire logic param_ack, // Accepted
   input wire logic param_err, // Refused
   input wire logic servo_on_output, // Servo-on out
   input wire logic nv_store_enable, // Storage allowed
   input wire logic simulation_mode, // Simulation
   input wire logic [7:0] dsp_error_out, // Error code out
   input wire logic [FLT_WIDTH-1:0] fault_display, // Shown faults
   input wire logic [1:0] stiffness_band, // Band
   input wire logic [15:0] speed_response_eff, // Active level
   input wire logic gain_auto_update, // Tuner active
   input wire logic gain_load_measured // Load pulse
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic aux_wr = param_wr && param_addr == AUX_FUNC_ADDR;
   wire logic mode_wr = param_wr && param_addr == TUNING_MODE_ADDR;
   // Tuner flag lags the mode register by one cycle, so skip a write
   // that directly follows another mode write
   sequence s_leave_auto;
      gain_auto_update && mode_wr && param_wr_data == 16'h0 &&
      !$past(mode_wr);
   endsequence
   sequence s_load_pulse;
      gain_load_measured ##1 !gain_load_measured && !gain_auto_update;
   endsequence
   property p_load;
      s_leave_auto |=> s_load_pulse;
   endproperty
   property p_force;
      aux_wr && param_wr_data == AUX_FORCE_SERVO_ON |-> ##2 servo_on_output;
   endproperty
   property p_volatile;
      aux_wr && param_wr_data == AUX_VOLATILE |-> ##2 !nv_store_enable;
   endproperty
   property p_zero;
      aux_wr && param_wr_data == AUX_NONE |-> ##2
      !simulation_mode && nv_store_enable;
   endproperty
   property p_sim_servo;
      simulation_mode |-> !servo_on_output;
   endproperty
   property p_sim_err;
      simulation_mode |-> dsp_error_out == 8'h0 && nv_store_enable;
   endproperty
   property p_sim_flt;
      simulation_mode |-> (fault_display & MOTOR_FAULT_MASK) == 6'h0;
   endproperty
   property p_range;
      mode_wr && param_wr_data > TUNING_MODE_MAX |=> param_err && !param_ack;
   endproperty
   property p_manual;
      !gain_auto_update |->
      speed_response_eff == 16'h0 && stiffness_band == 2'h0;
   endproperty
   property p_auto;
      mode_wr && (param_wr_data == 16'h1 || param_wr_data == 16'h2) |-> ##2
      gain_auto_update;
   endproperty
   a_load: assert property (p_load) else $error("no load pulse");
   a_force: assert property (p_force) else $error("servo not forced");
   a_volatile: assert property (p_volatile) else $error("storage on");
   a_zero: assert property (p_zero) else $error("aux not off");
   a_sim_servo: assert property (p_sim_servo) else $error("servo on");
   a_sim_err: assert property (p_sim_err) else $error("error code");
   a_sim_flt: assert property (p_sim_flt) else $error("motor fault");
   a_range: assert property (p_range) else $error("bad mode taken");
   a_manual: assert property (p_manual) else $error("level active");
   a_auto: assert property (p_auto) else $error("tuner idle");
endmodule
bind aux_function_tuning_params aux_tuning_checker u_chk (.sys_clk, .rst,
   .param_addr, .param_wr_data, .param_wr, .param_ack, .param_err,
   .servo_on_output, .nv_store_enable, .simulation_mode, .dsp_error_out,
   .fault_display, .stiffness_band, .speed_response_eff, .gain_auto_update,
   .gain_load_measured);
`default_nettype wire

/* File: bench/param_host.sv */
`timescale 1ns/10ps
`default_nettype none
module param_host (
   input wire logic sys_clk, // Clock
   input wire logic param_ack, // Accepted
   input wire logic param_err, // Refused
   input wire logic [15:0] param_rd_data, // Read value
   output logic [15:0] param_addr, // Address
   output logic [15:0] param_wr_data, // Write value
   output logic param_wr, // Write strobe
   output logic param_rd // Read strobe
);
   initial begin
      param_addr = 16'h0;
      param_wr_data = 16'h0;
      param_wr = 1'b0;
      param_rd = 1'b0;
   end
   task automatic access(input logic w, input logic [15:0] a, d,
                         output logic [15:0] q, output logic ok);
      int n;
      @(negedge sys_clk);
      param_addr = a;
      param_wr_data = d;
      param_wr = w;
      param_rd = !w;
      @(negedge sys_clk);
      param_wr = 1'b0;
      param_rd = 1'b0;
      // Idle bus shows no stale address or data
      param_addr = ~a;
      param_wr_data = ~d;
      n = 0;
      while (param_ack !== 1'b1 && param_err !== 1'b1 && n < 4) begin
         @(negedge sys_clk);
         n++;
      end
      q = param_rd_data;
      ok = param_ack;
   endtask
endmodule
`default_nettype wire

/* File: bench/aux_function_tuning_params_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module aux_function_tuning_params_tb;
   import aux_tuning_pkg::*;
   logic sys_clk, rst, param_wr, param_rd, param_ack, param_err, ok;
   logic [15:0] param_addr, param_wr_data, param_rd_data, rd, lvl;
   logic [15:0] speed_response_eff, pos_response;
   logic servo_on_in, servo_on_output, nv_store_enable, simulation_mode;
   logic gain_auto_update, gain_load_measured;
   logic [FLT_WIDTH-1:0] fault_in, fault_display;
   logic [7:0] dsp_error_code, dsp_error_out;
   logic [3:0] gain_switch_condition;
   logic [31:0] gain_switch_threshold, threshold_value;
   logic [1:0] threshold_unit, stiffness_band;
   int error_cnt, checked, md, pm;
   logic [15:0] ra[3] = '{AUX_FUNC_ADDR, SPEED_RESP_ADDR, TUNING_MODE_ADDR};
   logic [15:0] rv[3] = '{AUX_FUNC_RESET, SPEED_RESP_RESET, TUNING_MODE_RESET};
   logic [15:0] ac[4] = '{16'h1, 16'h5, 16'h6, 16'h0};
   logic [15:0] cn[8] = '{16'h1, 16'h32, 16'h33, 16'hfa, 16'hfb, 16'h226,
                          16'h227, 16'h3e8};
   logic [15:0] ba[5] = '{SPEED_RESP_ADDR, SPEED_RESP_ADDR, TUNING_MODE_ADDR,
                          AUX_FUNC_ADDR, AUX_FUNC_ADDR};
   logic [15:0] bd[5] = '{16'h0, 16'h3e9, 16'h3, 16'h9, 16'hfff7};
   aux_function_tuning_params DUT (.sys_clk, .rst, .param_addr,
      .param_wr_data, .param_wr, .param_rd, .param_rd_data, .param_ack,
      .param_err, .servo_on_in, .fault_in, .dsp_error_code,
      .gain_switch_condition, .gain_switch_threshold, .servo_on_output,
      .nv_store_enable, .simulation_mode, .dsp_error_out, .fault_display,
      .threshold_unit, .threshold_value, .stiffness_band, .speed_response_eff,
      .pos_response, .gain_auto_update, .gain_load_measured);
   param_host host (.sys_clk, .param_ack, .param_err, .param_rd_data,
      .param_addr, .param_wr_data, .param_wr, .param_rd);
   // ----------------------------------------------------------------
   // Checking and expectations
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, d);
      host.access(1'b1, a, d, rd, ok);
   endtask
   function automatic logic [1:0] band(input logic [15:0] l);
      if (l == 16'h0 || l > BAND_HIGH_MAX) return BAND_NONE;
      if (l <= BAND_LOW_MAX) return BAND_LOW;
      if (l <= BAND_MED_MAX) return BAND_MED;
      return BAND_HIGH;
   endfunction
   function automatic logic [1:0] unit(input int c);
      if (c == 2 || c == 6) return UNIT_PULSE;
      if (c == 3 || c == 7) return UNIT_KPPS;
      if (c == 4 || c == 8) return UNIT_RPM;
      return UNIT_NONE;
   endfunction
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #100us;
      error_cnt++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      servo_on_in = 1'b0;
      fault_in = 6'h3f;
      dsp_error_code = 8'h6f;
      gain_switch_condition = 4'h0;
      gain_switch_threshold = 32'h0;
      void'($urandom(38));
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      foreach (ra[i]) begin
         host.access(1'b0, ra[i], 16'h0, rd, ok);
         check("reset value", rd, rv[i]);
      end
      host.access(1'b0, 16'h0242, 16'h0, rd, ok);
      check("unmapped ack", ok, 1'b0);
      for (int p = 0; p < 2; p++) begin
         servo_on_in = 1'(p);
         // Step the selector through force servo-on, volatile and simulation, then back to zero
         foreach (ac[i]) begin
            wr(AUX_FUNC_ADDR, ac[i]);
            repeat (3) @(negedge sys_clk);
            check("servo", servo_on_output, ac[i] != AUX_SIMULATION &&
                  (ac[i] == AUX_FORCE_SERVO_ON || p == 1));
            check("nv store", nv_store_enable, ac[i] != AUX_VOLATILE);
            check("sim", simulation_mode, ac[i] == AUX_SIMULATION);
            check("dsp err", dsp_error_out,
                  ac[i] == AUX_SIMULATION ? 8'h0 : 8'h6f);
            check("faults", fault_display,
                  ac[i] == AUX_SIMULATION ? 6'h38 : 6'h3f);
         end
      end
      pm = 0;
      for (int i = 0; i < 24; i++) begin
         lvl = i < 8 ? cn[i] : 16'($urandom_range(1000, 1));
         md = i % 3;
         wr(SPEED_RESP_ADDR, lvl);
         wr(TUNING_MODE_ADDR, 16'(md));
         check("load", gain_load_measured, pm != 0 && md == 0);
         pm = md;
         @(negedge sys_clk);
         check("band", stiffness_band, md != 0 ? band(lvl) : BAND_NONE);
         check("eff", speed_response_eff, md != 0 ? lvl : 16'h0);
         check("pos", pos_response,
               md != 0 ? lvl >> POS_RESP_SHIFT : 16'h0);
         check("auto", gain_auto_update, md != 0);
      end
      wr(AUX_FUNC_ADDR, 16'hfff8);
      check("aux min ack", ok, 1'b1);
      foreach (ba[i]) begin
         wr(ba[i], bd[i]);
         check("range ack", ok, 1'b0);
      end
      host.access(1'b0, AUX_FUNC_ADDR, 16'h0, rd, ok);
      check("aux kept", rd, 16'hfff8);
      host.access(1'b0, SPEED_RESP_ADDR, 16'h0, rd, ok);
      check("speed kept", rd, lvl);
      host.access(1'b0, TUNING_MODE_ADDR, 16'h0, rd, ok);
      check("mode kept", rd, 16'(md));
      wr(AUX_FUNC_ADDR, 16'h0);
      for (int c = 0; c < 9; c++) begin
         gain_switch_condition = 4'(c);
         gain_switch_threshold = $urandom_range(3840000, 0);
         repeat (2) @(negedge sys_clk);
         check("unit", threshold_unit, unit(c));
         check("threshold", threshold_value, gain_switch_threshold);
      end
      complete_run();
   end
endmodule
`default_nettype wire
